// file: adc_sequencer_12bit_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
module adc_sequencer_12bit_tb;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic cmp, pwr, smp, bsel, bs, rd_d = 1'b0;
  logic [7:0] o_rdata, route, last;
  logic [11:0] trial, prev, vin = 12'h000;
  logic [6:0] iso;
  logic [15:0] q[$];
  logic [31:0] seed = 32'h0000003B;
  logic [2:0] ck [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  int dv [5] = '{16, 8, 4, 2, 1};
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0, d;
  always #10 i_mclk = ~i_mclk;
  adcs_top u_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_above(cmp),
    .o_converter_power_on(pwr), .o_sample(smp), .o_dac_trial(trial),
    .o_channel_route(route), .o_battery_divider_select(bsel), .o_pin_analog_isolation(iso));
  adcs_ain_model u_ain (.i_trial(trial), .i_level(vin), .i_route(route), .o_above(cmp));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    xs = r ^ (r << 5);
  endfunction : xs
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  // Mask zero marks a polling read that is not compared
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    q.push_back({e, m});
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(posedge i_mclk);
    #1;
  endtask : rd
  task automatic wrap_up;
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  always @(posedge i_mclk) begin
    logic [15:0] n;
    rd_d <= i_rd;
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      wrap_up();
    end
    if (rd_d && q.size() > 0) begin
      n = q.pop_front();
      last <= o_rdata;
      if (n[7:0] != 8'h00) chk(12'(o_rdata & n[7:0]), 12'(n[15:8] & n[7:0]));
    end
  end
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    rd(8'hB1, 8'h00, 8'hFF);
    rd(8'hB0, 8'h00, 8'hFF);
    rd(8'hB3, 8'h00, 8'h70);
    wr(8'hB1, 8'h50);
    rd(8'hB1, 8'h10, 8'hFF);
    seed = xs(seed);
    wr(8'hBE, seed[7:0]);
    #1 chk(12'(iso), 12'(seed[6:0]));
    rd(8'hBE, 8'h00, 8'hFF);
    wr(8'hB1, 8'h90);
    repeat (5000) @(posedge i_mclk);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      bs = seed[12];
      vin = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : seed[11:0];
      wr(8'hB3, {1'b0, ck[i % 5], 4'h0});
      wr(8'hB1, {4'hD, bs, i[2:0]});
      t0 = cyc;
      rd(8'hB1, {4'hD, bs, i[2:0]}, 8'hFF);
      do rd(8'hB1, 8'h00, 8'h00);
      while (!last[5] && cyc - t0 < 3000);
      d = cyc - t0;
      chk(12'(d >= 64 * dv[i % 5] && d <= 65 * dv[i % 5] + 12), 12'h001);
      rd(8'hB1, {4'hB, bs, i[2:0]}, 8'hFF);
      rd(8'hB2, vin[11:4], 8'hFF);
      rd(8'hB3, {1'b0, ck[i % 5], vin[3:0]}, 8'hFF);
    end
    prev = vin;
    vin = ~prev;
    wr(8'hB1, 8'hD2);
    wr(8'hB1, 8'h10);
    rd(8'hB1, 8'h10, 8'hFF);
    rd(8'hB2, prev[11:4], 8'hFF);
    wrap_up();
  end
endmodule : adc_sequencer_12bit_tb

// file: adcs_ain_model.sv
// Analog input and comparator stand-in
`timescale 1ns/1ns
module adcs_ain_model (
  input wire logic [11:0] i_trial,
  input wire logic [11:0] i_level,
  input wire logic [7:0] i_route,
  output logic o_above
);
  // Unrouted input floats, so it follows a changing pattern
  assign o_above = (i_route != 8'h00) ? (i_trial > i_level) : i_trial[0];
endmodule : adcs_ain_model

// file: adcs_clk_div.sv
// Converter clock tick generator, divided from the CPU clock
`timescale 1ns/1ns
`include "adcs_regs.svh"
module adcs_clk_div #(
  parameter int CW = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_run,
  input wire logic [2:0] i_sel,
  output logic o_tick
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] last;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    unique case (i_sel)
      `ADCS_CLK_DIV8: last = CW'(7);
      `ADCS_CLK_DIV4: last = CW'(3);
      `ADCS_CLK_DIV2: last = CW'(1);
      `ADCS_CLK_DIV1: last = CW'(0);
      // Unlisted codes fall back to the slowest rate
      default: last = CW'(15);
    endcase
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (!i_run) begin
      cnt_nxt = '0;
    end else if (cnt_r >= last) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + CW'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign o_tick = tick_r;
endmodule : adcs_clk_div

// file: adcs_pkg.sv
// Types shared by the converter sequencer files
package adcs_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_DONE
  } adcs_state_type;

  typedef struct packed {
    logic power;
    logic start;
    logic eoc;
    logic connect;
    logic batsel;
    logic [2:0] chan;
  } adcs_ctrl_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcs_bus_type;
endpackage : adcs_pkg

// file: adcs_props.sv
// Port checker for the converter sequencer
`timescale 1ns/1ns
module adcs_props (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_converter_power_on,
  input wire logic o_sample,
  input wire logic [7:0] o_channel_route,
  input wire logic o_battery_divider_select,
  input wire logic [6:0] o_pin_analog_isolation
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);
  logic wc;
  assign wc = i_wr && i_addr == 8'hB1;
  chk_route_onehot: assert property ($onehot0(o_channel_route))
    else $error("route not one-hot");
  chk_route_power: assert property (o_channel_route != 8'h00 |-> o_converter_power_on)
    else $error("route while off");
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside slot");
  chk_power_bit: assert property (wc |=> o_converter_power_on == $past(i_wdata[7]))
    else $error("power bit");
  chk_battery_bit: assert property (wc |=> o_battery_divider_select == $past(i_wdata[3]))
    else $error("battery select");
  chk_iso_bits: assert property (i_wr && i_addr == 8'hBE |=>
    o_pin_analog_isolation == $past(i_wdata[6:0]))
    else $error("isolation bits");
  chk_route_chan: assert property (wc && i_wdata[7] && i_wdata[4] |=>
    o_channel_route == 8'h01 << $past(i_wdata[2:0]))
    else $error("route channel");
  chk_sample_cause: assert property (o_sample |-> $past(wc && i_wdata[7] && i_wdata[6]))
    else $error("sample without start");
endmodule : adcs_props
bind adcs_top adcs_props u_props (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_converter_power_on(o_converter_power_on), .o_sample(o_sample),
  .o_channel_route(o_channel_route), .o_battery_divider_select(o_battery_divider_select),
  .o_pin_analog_isolation(o_pin_analog_isolation));

// file: adcs_regs.svh
// Register map, field positions and timing constants of the converter sequencer
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH
`define ADCS_OFS_CTRL 8'hB1
`define ADCS_OFS_RES_HI 8'hB2
`define ADCS_OFS_CLK_LO 8'hB3
`define ADCS_OFS_ISO 8'hBE
`define ADCS_CTRL_RESET 8'h00
`define ADCS_ISO_RESET 7'h00
`define ADCS_CLKSEL_RESET 3'h0
`define ADCS_BIT_POWER 7
`define ADCS_BIT_START 6
`define ADCS_BIT_EOC 5
`define ADCS_BIT_CONNECT 4
`define ADCS_BIT_BATSEL 3
`define ADCS_CHAN_HI 2
`define ADCS_CHAN_LO 0
`define ADCS_CLK_HI 6
`define ADCS_CLK_LO 4
`define ADCS_CLK_DIV16 3'h0
`define ADCS_CLK_DIV8 3'h4
`define ADCS_CLK_DIV4 3'h5
`define ADCS_CLK_DIV2 3'h6
`define ADCS_CLK_DIV1 3'h7
`define ADCS_CHAN_BATTERY 3'h7
`define ADCS_STEPS 16
`define ADCS_CLKS_PER_STEP 4
`define ADCS_RESULT_BITS 12
`endif

// file: adcs_top.sv
// Successive-approximation converter sequencer with its register port
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`include "adcs_regs.svh"
module adcs_top #(
  parameter int NBITS = `ADCS_RESULT_BITS,
  parameter int NSTEPS = `ADCS_STEPS,
  parameter int CLKS_PER_STEP = `ADCS_CLKS_PER_STEP
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_cmp_above,
  output logic o_converter_power_on,
  output logic o_sample,
  output logic [NBITS-1:0] o_dac_trial,
  output logic [7:0] o_channel_route,
  output logic o_battery_divider_select,
  output logic [6:0] o_pin_analog_isolation
);
  localparam int SW = $clog2(NSTEPS * CLKS_PER_STEP + 1);

  adcs_pkg::adcs_bus_type bus;
  adcs_pkg::adcs_ctrl_type ctrl_r;
  adcs_pkg::adcs_ctrl_type ctrl_nxt;
  adcs_pkg::adcs_state_type st_r;
  adcs_pkg::adcs_state_type st_nxt;
  logic [2:0] clksel_r;
  logic [2:0] clksel_nxt;
  logic [6:0] iso_r;
  logic [6:0] iso_nxt;
  logic [NBITS-1:0] res_r;
  logic [NBITS-1:0] res_nxt;
  logic [NBITS-1:0] trial_r;
  logic [NBITS-1:0] trial_nxt;
  logic [NBITS-1:0] bitmask_r;
  logic [NBITS-1:0] bitmask_nxt;
  logic [SW-1:0] ticks_r;
  logic [SW-1:0] ticks_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] route_r;
  logic [7:0] route_nxt;
  logic sample_r;
  logic sample_nxt;
  logic tick;
  logic run;
  logic finish;
  logic launch;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign run = (st_r == adcs_pkg::ST_CONVERT);

  adcs_clk_div #(
    .CW(4)
  ) u_div (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_run(run),
    .i_sel(clksel_r),
    .o_tick(tick)
  );

  // Control register, clock select and isolation writes
  always_comb begin
    ctrl_nxt = ctrl_r;
    clksel_nxt = clksel_r;
    iso_nxt = iso_r;
    launch = 1'b0;
    if (bus.wr && bus.addr == `ADCS_OFS_CTRL) begin
      ctrl_nxt.power = bus.wdata[`ADCS_BIT_POWER];
      ctrl_nxt.connect = bus.wdata[`ADCS_BIT_CONNECT];
      ctrl_nxt.batsel = bus.wdata[`ADCS_BIT_BATSEL];
      ctrl_nxt.chan = bus.wdata[`ADCS_CHAN_HI:`ADCS_CHAN_LO];
      // Start only takes while powered; a busy converter keeps running
      if (bus.wdata[`ADCS_BIT_START] && bus.wdata[`ADCS_BIT_POWER]) begin
        ctrl_nxt.start = 1'b1;
        launch = !ctrl_r.start;
      end else if (!bus.wdata[`ADCS_BIT_START]) begin
        ctrl_nxt.start = 1'b0;
      end
      // Software may clear the end flag; hardware set below still wins
      if (!bus.wdata[`ADCS_BIT_EOC]) begin
        ctrl_nxt.eoc = 1'b0;
      end
    end
    if (!ctrl_nxt.power) begin
      ctrl_nxt.start = 1'b0;
    end
    if (launch) begin
      ctrl_nxt.eoc = 1'b0;
    end
    if (finish) begin
      ctrl_nxt.eoc = 1'b1;
      ctrl_nxt.start = 1'b0;
    end
    if (bus.wr && bus.addr == `ADCS_OFS_CLK_LO) begin
      clksel_nxt = bus.wdata[`ADCS_CLK_HI:`ADCS_CLK_LO];
    end
    if (bus.wr && bus.addr == `ADCS_OFS_ISO) begin
      iso_nxt = bus.wdata[6:0];
    end
  end

  // Successive approximation sequencer
  always_comb begin
    st_nxt = st_r;
    trial_nxt = trial_r;
    bitmask_nxt = bitmask_r;
    ticks_nxt = ticks_r;
    res_nxt = res_r;
    sample_nxt = 1'b0;
    finish = 1'b0;
    unique case (st_r)
      adcs_pkg::ST_IDLE: begin
        if (launch) begin
          st_nxt = adcs_pkg::ST_CONVERT;
          ticks_nxt = '0;
          bitmask_nxt = {1'b1, {(NBITS-1){1'b0}}};
          trial_nxt = {1'b1, {(NBITS-1){1'b0}}};
          sample_nxt = 1'b1;
        end
      end
      adcs_pkg::ST_CONVERT: begin
        if (!ctrl_r.power || !ctrl_r.start) begin
          // Abort on power-down or software stop; result left untouched
          st_nxt = adcs_pkg::ST_IDLE;
        end else if (tick) begin
          ticks_nxt = ticks_r + SW'(1);
          // Bits resolve at the ends of the first twelve steps
          if (ticks_r[1:0] == 2'h3 && bitmask_r != '0) begin
            if (i_cmp_above) begin
              trial_nxt = trial_r & ~bitmask_r;
            end
            bitmask_nxt = bitmask_r >> 1;
            trial_nxt = trial_nxt | (bitmask_r >> 1);
          end
          if (ticks_r == SW'(NSTEPS * CLKS_PER_STEP - 1)) begin
            st_nxt = adcs_pkg::ST_DONE;
          end
        end
      end
      adcs_pkg::ST_DONE: begin
        res_nxt = trial_r;
        finish = 1'b1;
        st_nxt = adcs_pkg::ST_IDLE;
      end
      default: begin
        st_nxt = adcs_pkg::ST_IDLE;
      end
    endcase
  end

  // Routing to pins and read data
  always_comb begin
    route_nxt = '0;
    // Next control word, so routing lands with the control bits, not a cycle late
    if (ctrl_nxt.power && ctrl_nxt.connect) begin
      route_nxt[ctrl_nxt.chan] = 1'b1;
    end
    rdata_nxt = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `ADCS_OFS_CTRL: rdata_nxt = ctrl_r;
        `ADCS_OFS_RES_HI: rdata_nxt = res_r[NBITS-1:NBITS-8];
        `ADCS_OFS_CLK_LO: rdata_nxt = {1'b0, clksel_r, res_r[3:0]};
        // Isolation register is write-only and reads as zero
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_r <= `ADCS_CTRL_RESET;
      clksel_r <= `ADCS_CLKSEL_RESET;
      iso_r <= `ADCS_ISO_RESET;
      st_r <= adcs_pkg::ST_IDLE;
      trial_r <= '0;
      bitmask_r <= '0;
      ticks_r <= '0;
      rdata_r <= 8'h00;
      route_r <= 8'h00;
      sample_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      clksel_r <= clksel_nxt;
      iso_r <= iso_nxt;
      st_r <= st_nxt;
      trial_r <= trial_nxt;
      bitmask_r <= bitmask_nxt;
      ticks_r <= ticks_nxt;
      rdata_r <= rdata_nxt;
      route_r <= route_nxt;
      sample_r <= sample_nxt;
    end
  end

  // Result holds no reset so its power-up contents are undefined
  always_ff @(posedge i_mclk) begin
    res_r <= res_nxt;
  end

  assign o_rdata = rdata_r;
  assign o_converter_power_on = ctrl_r.power;
  assign o_sample = sample_r;
  assign o_dac_trial = trial_r;
  assign o_channel_route = route_r;
  assign o_battery_divider_select = ctrl_r.batsel;
  assign o_pin_analog_isolation = iso_r;
endmodule : adcs_top
